// file: pkg/cmp_ctrl_pkg.sv
// Functional notes
// - result high when positive input exceeds negative
// - mux enable, converter off: channel drives negative
// - otherwise dedicated negative pin drives comparator
// - bandgap select swaps positive pin for reference
// - result synchronized, one to two cycles late
// - comparator off bit powers comparator down
// - mode 00 toggle, 01 reserved, 10 fall, 11 rise
// - selected event sets flag regardless of enable
// - request while flag, enable and global enable
// - vector acknowledge clears the event flag
// - writing one clears flag, zero keeps it
// - capture route feeds result to timer capture
// - buffer off bit blanks pin read value
// - reserved pin register bits read zero
// - converter enable input is converter's enable bit
package cmp_ctrl_pkg;

	// ------------------------------------------------------------------
	// bus geometry and register map
	// ------------------------------------------------------------------
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned SEL_W  = 4;
	localparam int unsigned REG_W  = 8;

	localparam logic [ADDR_W-1:0] OFS_CONV_CS_B  = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_CMP_CS     = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_PIN_OFF    = 4'h8;

	localparam logic [REG_W-1:0]  RST_CONV_CS_B  = 8'h00;
	localparam logic [REG_W-1:0]  RST_CMP_CS     = 8'h00;
	localparam logic [REG_W-1:0]  RST_PIN_OFF    = 8'h00;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int unsigned NEG_MUX_EN_BIT = 6;
	localparam int unsigned TRIG_SRC_LSB   = 0;
	localparam int unsigned TRIG_SRC_W     = 3;

	localparam int unsigned CMP_OFF_BIT    = 7;
	localparam int unsigned BANDGAP_BIT    = 6;
	localparam int unsigned RESULT_BIT     = 5;
	localparam int unsigned FLAG_BIT       = 4;
	localparam int unsigned IRQ_EN_BIT     = 3;
	localparam int unsigned CAPTURE_BIT    = 2;
	localparam int unsigned MODE_LSB       = 0;
	localparam int unsigned MODE_W         = 2;

	localparam int unsigned NEG_BUF_BIT    = 1;
	localparam int unsigned POS_BUF_BIT    = 0;
	localparam int unsigned PIN_OFF_W      = 2;

	localparam int unsigned CHAN_W         = 3;

	// ------------------------------------------------------------------
	// synchronizer lanes
	// ------------------------------------------------------------------
	localparam int unsigned SYNC_W       = 3;
	localparam int unsigned LANE_RESULT  = 0;
	localparam int unsigned LANE_POS_PIN = 1;
	localparam int unsigned LANE_NEG_PIN = 2;

	typedef enum logic [1:0] {
		MODE_TOGGLE   = 2'b00,
		MODE_RESERVED = 2'b01,
		MODE_FALL     = 2'b10,
		MODE_RISE     = 2'b11
	} event_mode_t;

endpackage

// file: pkg/sync_lane_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sync_lane_if #(parameter int unsigned W = 1);
	logic [W-1:0] raw;
	logic [W-1:0] level;
	logic [W-1:0] rise;
	logic [W-1:0] fall;

	modport sync (input raw, output level, output rise, output fall);
	modport user (output raw, input level, input rise, input fall);
endinterface
`default_nettype wire

// file: rtl/cmp_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module cmp_ctrl (
	input  wire logic                                    clk_i,
	input  wire logic                                    rst_i,
	// wishbone classic slave
	input  wire logic                                    cyc_i,
	input  wire logic                                    stb_i,
	input  wire logic                                    we_i,
	input  wire logic [cmp_ctrl_pkg::ADDR_W-1:0]         adr_i,
	input  wire logic [cmp_ctrl_pkg::SEL_W-1:0]          sel_i,
	input  wire logic [cmp_ctrl_pkg::DATA_W-1:0]         dat_i,
	output logic [cmp_ctrl_pkg::DATA_W-1:0]              dat_o,
	output logic                                         ack_o,
	// analog comparator and pins
	input  wire logic                                    cmp_raw_i,
	input  wire logic                                    pos_pin_i,
	input  wire logic                                    neg_pin_i,
	output logic                                         comparator_off_o,
	output logic                                         pos_from_bandgap_o,
	output logic                                         neg_from_channel_o,
	output logic [cmp_ctrl_pkg::CHAN_W-1:0]              neg_channel_o,
	output logic                                         pos_pin_buffer_off_o,
	output logic                                         neg_pin_buffer_off_o,
	output logic                                         pos_pin_read_o,
	output logic                                         neg_pin_read_o,
	// converter block
	input  wire logic                                    converter_enable_i,
	input  wire logic [cmp_ctrl_pkg::CHAN_W-1:0]         channel_select_i,
	output logic [cmp_ctrl_pkg::TRIG_SRC_W-1:0]          auto_trigger_source_o,
	// processor and timer
	input  wire logic                                    global_irq_enable_i,
	input  wire logic                                    irq_ack_i,
	output logic                                         irq_o,
	output logic                                         capture_input_o
);
	import cmp_ctrl_pkg::*;

	// ------------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------------
	logic                    ack_q;
	logic [DATA_W-1:0]       rdata_q;
	logic                    req;
	logic                    wr_commit;
	logic                    wr_cs;

	logic                    neg_mux_enable_q;
	logic [TRIG_SRC_W-1:0]   trig_src_q;
	logic                    comparator_off_q;
	logic                    bandgap_select_q;
	logic                    compare_event_flag_q;
	logic                    compare_irq_enable_q;
	logic                    capture_route_enable_q;
	event_mode_t             event_mode_q;
	logic [PIN_OFF_W-1:0]    pin_buffer_off_q;
	logic                    comparison_result;
	logic                    event_hit;
	logic                    pos_read_q;
	logic                    neg_read_q;
	logic [REG_W-1:0]        rd_byte;

	sync_lane_if #(.W(SYNC_W)) lanes ();

	assign req       = cyc_i & stb_i;
	// write lands on the edge where the master sees ack
	assign wr_commit = req & we_i & ack_q & sel_i[0];
	assign wr_cs     = wr_commit & (adr_i == OFS_CMP_CS);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_q <= 1'b0;
		else
			ack_q <= req & ~ack_q;
	end

	assign ack_o = ack_q;

	always_comb
	begin
		case (adr_i)
			OFS_CONV_CS_B:
				rd_byte = {1'b0, neg_mux_enable_q, 3'h0, trig_src_q};
			OFS_CMP_CS:
				rd_byte = {comparator_off_q, bandgap_select_q, comparison_result,
					compare_event_flag_q, compare_irq_enable_q, capture_route_enable_q,
					event_mode_q};
			OFS_PIN_OFF:
				rd_byte = {6'h00, pin_buffer_off_q};
			default:
				rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rdata_q <= '0;
		else
			rdata_q <= {{(DATA_W-REG_W){1'b0}}, rd_byte};
	end

	assign dat_o = rdata_q;

	// ------------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			neg_mux_enable_q <= RST_CONV_CS_B[NEG_MUX_EN_BIT];
			trig_src_q       <= RST_CONV_CS_B[TRIG_SRC_LSB +: TRIG_SRC_W];
		end
		else if (wr_commit && adr_i == OFS_CONV_CS_B)
		begin
			neg_mux_enable_q <= dat_i[NEG_MUX_EN_BIT];
			trig_src_q       <= dat_i[TRIG_SRC_LSB +: TRIG_SRC_W];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			comparator_off_q       <= RST_CMP_CS[CMP_OFF_BIT];
			bandgap_select_q       <= RST_CMP_CS[BANDGAP_BIT];
			compare_irq_enable_q   <= RST_CMP_CS[IRQ_EN_BIT];
			capture_route_enable_q <= RST_CMP_CS[CAPTURE_BIT];
			event_mode_q           <= event_mode_t'(RST_CMP_CS[MODE_LSB +: MODE_W]);
		end
		else if (wr_cs)
		begin
			comparator_off_q       <= dat_i[CMP_OFF_BIT];
			bandgap_select_q       <= dat_i[BANDGAP_BIT];
			compare_irq_enable_q   <= dat_i[IRQ_EN_BIT];
			capture_route_enable_q <= dat_i[CAPTURE_BIT];
			event_mode_q           <= event_mode_t'(dat_i[MODE_LSB +: MODE_W]);
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			pin_buffer_off_q <= RST_PIN_OFF[0 +: PIN_OFF_W];
		else if (wr_commit && adr_i == OFS_PIN_OFF)
			pin_buffer_off_q <= dat_i[0 +: PIN_OFF_W];
	end

	assign auto_trigger_source_o = trig_src_q;

	// ------------------------------------------------------------------
	// input selection for the analog comparator
	// ------------------------------------------------------------------
	assign comparator_off_o     = comparator_off_q;
	assign pos_from_bandgap_o   = bandgap_select_q;
	assign neg_from_channel_o   = neg_mux_enable_q & ~converter_enable_i;
	assign neg_channel_o        = neg_from_channel_o ? channel_select_i : '0;
	assign pos_pin_buffer_off_o = pin_buffer_off_q[POS_BUF_BIT];
	assign neg_pin_buffer_off_o = pin_buffer_off_q[NEG_BUF_BIT];

	// ------------------------------------------------------------------
	// synchronizers and result
	// ------------------------------------------------------------------
	// raw inputs meet nothing but the synchronizer flops
	assign lanes.raw = {neg_pin_i, pos_pin_i, cmp_raw_i};

	lane_sync #(.W(SYNC_W)) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.lanes (lanes.sync)
	);

	assign comparison_result = lanes.level[LANE_RESULT];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pos_read_q <= 1'b0;
			neg_read_q <= 1'b0;
		end
		else
		begin
			pos_read_q <= lanes.level[LANE_POS_PIN] & ~pin_buffer_off_q[POS_BUF_BIT];
			neg_read_q <= lanes.level[LANE_NEG_PIN] & ~pin_buffer_off_q[NEG_BUF_BIT];
		end
	end

	assign pos_pin_read_o = pos_read_q;
	assign neg_pin_read_o = neg_read_q;

	// ------------------------------------------------------------------
	// event detection and flag
	// ------------------------------------------------------------------
	always_comb
	begin
		case (event_mode_q)
			MODE_TOGGLE:
				event_hit = lanes.rise[LANE_RESULT] | lanes.fall[LANE_RESULT];
			MODE_FALL:
				event_hit = lanes.fall[LANE_RESULT];
			MODE_RISE:
				event_hit = lanes.rise[LANE_RESULT];
			default:
				event_hit = 1'b0;
		endcase
	end

	// set wins over either clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			compare_event_flag_q <= RST_CMP_CS[FLAG_BIT];
		else if (event_hit)
			compare_event_flag_q <= 1'b1;
		else if (irq_ack_i)
			compare_event_flag_q <= 1'b0;
		else if (wr_cs && dat_i[FLAG_BIT])
			compare_event_flag_q <= 1'b0;
	end

	assign irq_o = compare_event_flag_q & compare_irq_enable_q & global_irq_enable_i;

	// no connection to capture logic unless routed
	assign capture_input_o = capture_route_enable_q & comparison_result;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	a_ack_latency: assert property (req && !ack_o |=> ack_o)
		else $error("ack not given one cycle after request");
	a_result_sync: assert property (lanes.raw[LANE_RESULT] [*2] |=> comparison_result)
		else $error("result not visible within two cycles");
	a_flag_sets: assert property (event_hit |=> compare_event_flag_q)
		else $error("event did not set flag");
	a_reserved_mode: assert property (event_mode_q == MODE_RESERVED
		&& !compare_event_flag_q && !wr_cs |=> !compare_event_flag_q)
		else $error("reserved mode set the flag");
	a_ack_clears: assert property (irq_ack_i && !event_hit |=> !compare_event_flag_q)
		else $error("acknowledge did not clear flag");
	a_write_clears: assert property (wr_cs && dat_i[FLAG_BIT] && !event_hit
		|=> !compare_event_flag_q)
		else $error("write one did not clear flag");
	a_write_keeps: assert property (compare_event_flag_q && wr_cs && !dat_i[FLAG_BIT]
		&& !irq_ack_i |=> compare_event_flag_q)
		else $error("write zero cleared flag");
	a_irq_from_event: assert property (event_hit && compare_irq_enable_q
		##1 compare_irq_enable_q && global_irq_enable_i |-> irq_o)
		else $error("flagged event raised no request");
	a_neg_pin_used: assert property (converter_enable_i || !neg_mux_enable_q
		|-> !neg_from_channel_o && neg_channel_o == '0)
		else $error("channel drives negative input while blocked");
	a_reserved_zero: assert property (ack_o && adr_i == OFS_PIN_OFF
		|-> dat_o[DATA_W-1:PIN_OFF_W] == '0)
		else $error("reserved pin bits read nonzero");
	a_buffer_blank: assert property (pin_buffer_off_q[POS_BUF_BIT] |=> !pos_pin_read_o)
		else $error("pin read not blanked");
	a_capture_off: assert property (!capture_route_enable_q |-> !capture_input_o)
		else $error("capture input driven while unrouted");
	a_write_lands: assert property (wr_cs |=>
		comparator_off_q == $past(dat_i[CMP_OFF_BIT])
		&& bandgap_select_q == $past(dat_i[BANDGAP_BIT]))
		else $error("control write did not land");
	a_neg_channel: assert property (neg_mux_enable_q && !converter_enable_i
		|-> neg_from_channel_o && neg_channel_o == channel_select_i)
		else $error("channel not routed to negative input");
	a_toggle_hit: assert property (event_mode_q == MODE_TOGGLE
		&& $changed(comparison_result) |-> event_hit)
		else $error("toggle did not raise an event");
	a_rise_hit: assert property (event_mode_q == MODE_RISE
		&& $rose(comparison_result) |-> event_hit)
		else $error("rising edge did not raise an event");
	a_fall_hit: assert property (event_mode_q == MODE_FALL
		&& $fell(comparison_result) |-> event_hit)
		else $error("falling edge did not raise an event");
	a_rise_only: assert property (event_mode_q == MODE_RISE
		&& $fell(comparison_result) |-> !event_hit)
		else $error("falling edge raised a rise event");
	a_ack_idle: assert property (!req |=> !ack_o)
		else $error("ack without request");
	a_read_upper: assert property (ack_o |-> dat_o[DATA_W-1:REG_W] == '0)
		else $error("upper read bits nonzero");
	a_capture_on: assert property (capture_route_enable_q
		|-> capture_input_o == comparison_result)
		else $error("capture input does not follow result");
	a_neg_blank: assert property (pin_buffer_off_q[NEG_BUF_BIT] |=> !neg_pin_read_o)
		else $error("negative pin read not blanked");
	a_pin_follows: assert property (!pin_buffer_off_q[POS_BUF_BIT]
		|=> pos_pin_read_o == $past(lanes.level[LANE_POS_PIN]))
		else $error("pin read does not follow pin");

	c_rise_event: cover property (event_mode_q == MODE_RISE ##0 event_hit);
	c_irq_raised: cover property (!irq_o ##1 irq_o);
	c_ack_clear: cover property (compare_event_flag_q && irq_ack_i ##1 !compare_event_flag_q);
	c_channel_neg: cover property (neg_from_channel_o);
	c_capture_route: cover property (capture_route_enable_q && capture_input_o);

endmodule
`default_nettype wire

// file: rtl/lane_sync.sv
`timescale 1ns/100ps
`default_nettype none
module lane_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic      clk_i,
	input  wire logic      rst_i,
	sync_lane_if.sync      lanes
);

	// ------------------------------------------------------------------
	// two-stage synchronizer plus history stage
	// ------------------------------------------------------------------
	logic [W-1:0] meta_q;
	logic [W-1:0] stable_q;
	logic [W-1:0] prev_q;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta_q   <= '0;
			stable_q <= '0;
			prev_q   <= '0;
		end
		else
		begin
			meta_q   <= lanes.raw;
			stable_q <= meta_q;
			prev_q   <= stable_q;
		end
	end

	// edges against value one clock earlier
	assign lanes.level = stable_q;
	assign lanes.rise  = stable_q & ~prev_q;
	assign lanes.fall  = ~stable_q & prev_q;

endmodule
`default_nettype wire

// file: sim/analog_side.sv
`timescale 1ns/100ps
`default_nettype none
module analog_side (
	input  wire logic [7:0]      pos_lvl_i,
	input  wire logic [7:0]      neg_lvl_i,
	input  wire logic [7:0][7:0] chan_lvl_i,
	input  wire logic            off_i,
	input  wire logic            bandgap_i,
	input  wire logic            from_chan_i,
	input  wire logic [2:0]      chan_i,
	input  wire logic            power_reduce_i,
	input  wire logic            capture_i,
	input  wire logic            capture_irq_enable_i,
	output logic                 raw_o,
	output logic                 capture_irq_o
);
	localparam logic [7:0] BANDGAP_LVL = 8'h80;
	logic [7:0] p;
	logic [7:0] n;
	assign p = bandgap_i ? BANDGAP_LVL : pos_lvl_i;
	// converter mux passes nothing while its power is cut
	assign n = !from_chan_i ? neg_lvl_i
		: power_reduce_i ? 8'h00 : chan_lvl_i[chan_i];
	// timer front end reduced to its interrupt mask
	assign capture_irq_o = capture_i && capture_irq_enable_i;
	// powered down comparator never reports high
	assign raw_o = !off_i && (p > n);
endmodule
`default_nettype wire

// file: sim/cmp_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module cmp_ctrl_tb;
	logic            clk_i, rst_i, cyc, stb, we, ack, raw;
	logic [3:0]      adr, sel;
	logic [31:0]     wdat, rdat;
	logic            off, bg, from_chan, pbo, nbo, prd, nrd, irq, cap;
	logic            pos_pin, neg_pin, conv_en, glob, irq_ack, pwr_red, cap_ien, cap_irq;
	logic [2:0]      neg_ch, chan, trig;
	logic [7:0]      pos_lvl, neg_lvl, q;
	logic [7:0][7:0] chan_lvl;
	int              mismatches, checks;

	cmp_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
		.cmp_raw_i(raw), .pos_pin_i(pos_pin), .neg_pin_i(neg_pin),
		.comparator_off_o(off), .pos_from_bandgap_o(bg), .neg_from_channel_o(from_chan),
		.neg_channel_o(neg_ch), .pos_pin_buffer_off_o(pbo), .neg_pin_buffer_off_o(nbo),
		.pos_pin_read_o(prd), .neg_pin_read_o(nrd), .converter_enable_i(conv_en),
		.channel_select_i(chan), .auto_trigger_source_o(trig),
		.global_irq_enable_i(glob), .irq_ack_i(irq_ack), .irq_o(irq),
		.capture_input_o(cap));

	analog_side model_u (.pos_lvl_i(pos_lvl), .neg_lvl_i(neg_lvl), .chan_lvl_i(chan_lvl),
		.off_i(off), .bandgap_i(bg), .from_chan_i(from_chan), .chan_i(neg_ch),
		.power_reduce_i(pwr_red), .capture_i(cap), .capture_irq_enable_i(cap_ien),
		.capture_irq_o(cap_irq), .raw_o(raw));

	always #2.5 clk_i = ~clk_i;

	// ----------------------------
	// bus access and checking
	// ----------------------------
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h000000, d};
		@(posedge clk_i);
		while (ack !== 1'b1)
			@(posedge clk_i);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		checks++;
		if (got !== exp)
		begin
			$display("wrong value at %0t: %s", $time, msg);
			mismatches++;
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk_i);
		@(negedge clk_i);
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		repeat (3000) @(posedge clk_i);
		mismatches++;
		stop_test();
	end

	initial
	begin
		clk_i = 1'b0;
		rst_i = 1'b1;
		{cyc, stb, we, adr, wdat, conv_en, chan, glob, irq_ack} = '0;
		sel = 4'hf;
		pos_pin = 1'b1;
		neg_pin = 1'b1;
		pwr_red = 1'b0;
		cap_ien = 1'b1;
		pos_lvl = 8'h00;
		neg_lvl = 8'h40;
		for (int i = 0; i < 8; i++)
			chan_lvl[i] = {i[3:0], 4'h0};
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, 4'h0, 0); chk(q, 8'h00, "conv reset");
		wb(0, 4'h4, 0); chk(q, 8'h00, "cmp reset");
		wb(0, 4'h8, 0); chk(q, 8'h00, "pin reset");
		wb(1, 4'hc, 8'hff);
		wb(0, 4'hc, 0); chk(q, 8'h00, "unmapped");
		settle(1); chk({nrd, prd}, 2'b11, "pin read on");
		wb(1, 4'h8, 8'hff);
		wb(0, 4'h8, 0); chk(q, 8'h03, "pin reg");
		settle(3); chk({nbo, pbo, nrd, prd}, 4'b1100, "pin blank");
		wb(1, 4'h8, 8'h00);
		wb(1, 4'h0, 8'hff);
		wb(0, 4'h0, 0); chk(q, 8'h47, "conv reg");
		chk(trig, 3'h7, "trigger src");
		sel <= 4'he;
		wb(1, 4'h0, 8'h00);
		sel <= 4'hf;
		wb(0, 4'h0, 0); chk(q, 8'h47, "lane off");
		pos_lvl <= 8'h38;
		for (int c = 0; c < 8; c++)
		begin
			chan <= c[2:0];
			settle(3); chk({from_chan, neg_ch}, {1'b1, c[2:0]}, "chan mux");
			wb(0, 4'h4, 0); chk(q[5], c < 4, "chan result");
		end
		conv_en <= 1'b1;
		settle(1); chk({from_chan, neg_ch}, 4'h0, "conv on");
		wb(1, 4'h0, 8'h00);
		conv_en <= 1'b0;
		settle(1); chk(from_chan, 0, "mux off");
		for (int m = 0; m < 4; m++)
		begin
			pos_lvl <= 8'h00;
			settle(4);
			wb(1, 4'h4, {6'h04, m[1:0]});
			pos_lvl <= 8'hff;
			settle(4);
			wb(0, 4'h4, 0); chk(q[5:4], {1'b1, m == 0 || m == 3}, "rise");
			wb(1, 4'h4, {6'h04, m[1:0]});
			pos_lvl <= 8'h00;
			settle(4);
			wb(0, 4'h4, 0); chk(q[5:4], {1'b0, m == 0 || m == 2}, "fall");
		end
		wb(1, 4'h4, 8'h10);
		wb(1, 4'h4, 8'h18);
		glob <= 1'b1;
		pos_lvl <= 8'hff;
		settle(4); chk(irq, 1, "irq on");
		@(posedge clk_i);
		glob <= 1'b0;
		settle(1); chk(irq, 0, "global off");
		@(posedge clk_i);
		glob <= 1'b1;
		irq_ack <= 1'b1;
		@(posedge clk_i);
		irq_ack <= 1'b0;
		settle(1); chk(irq, 0, "vector clear");
		pos_lvl <= 8'h00;
		settle(4);
		wb(1, 4'h4, 8'h08);
		wb(0, 4'h4, 0); chk(q[4], 1, "flag kept");
		wb(1, 4'h4, 8'h18);
		wb(0, 4'h4, 0); chk(q[4], 0, "flag cleared");
		wb(1, 4'h4, 8'h04);
		pos_lvl <= 8'hff;
		settle(4); chk(cap, 1, "capture");
		chk(cap_irq, 1, "capture irq");
		wb(1, 4'h4, 8'h00);
		settle(1); chk(cap, 0, "no capture");
		wb(1, 4'h4, 8'h80);
		settle(4); chk(off, 1, "off");
		wb(0, 4'h4, 0); chk(q[5], 0, "off result");
		wb(1, 4'h4, 8'h40);
		pos_lvl <= 8'h00;
		settle(4); chk(bg, 1, "bandgap");
		wb(0, 4'h4, 0); chk(q[5], 1, "bandgap result");
		stop_test();
	end
endmodule
`default_nettype wire
